// >>> common/ssmc_consts.svh
`ifndef SSMC_CONSTS_SVH
`define SSMC_CONSTS_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define SSMC_OFF_CTRL1      8'h00
`define SSMC_OFF_STATUS     8'h04
`define SSMC_OFF_CLEAR      8'h08
`define SSMC_OFF_ENABLE     8'h0C
`define SSMC_OFF_BAUD       8'h10
`define SSMC_OFF_DATA       8'h14
// ---------------------------------------------------------------
// control field positions
// ---------------------------------------------------------------
`define SSMC_BIT_OVF        6
`define SSMC_BIT_EN         5
`define SSMC_BIT_CKP        4
`define SSMC_MODE_MSB       3
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define SSMC_RST_CTRL1      8'h00
`define SSMC_RST_BAUD       8'h00
// ---------------------------------------------------------------
// status bit positions
// ---------------------------------------------------------------
`define SSMC_IRQ_OVF        0
`define SSMC_IRQ_RX         1
`define SSMC_IRQ_START      2
`define SSMC_IRQ_STOP       3
`endif

// >>> common/ssmc_pkg.sv
package ssmc_pkg;
  // ---------------------------------------------------------------
  // mode selector codes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    SSMC_SPI_M_DIV4   = 4'h0,
    SSMC_SPI_M_DIV16  = 4'h1,
    SSMC_SPI_M_DIV64  = 4'h2,
    SSMC_SPI_M_TIMER_TWO   = 4'h3,
    SSMC_SPI_S_SSEN   = 4'h4,
    SSMC_SPI_S_NOSS   = 4'h5,
    SSMC_I2C_S_7      = 4'h6,
    SSMC_I2C_S_10     = 4'h7,
    SSMC_RSVD_8       = 4'h8,
    SSMC_RSVD_9       = 4'h9,
    SSMC_SPI_M_BAUD   = 4'hA,
    SSMC_I2C_M_FW     = 4'hB,
    SSMC_RSVD_C       = 4'hC,
    SSMC_RSVD_D       = 4'hD,
    SSMC_I2C_S_7_INT  = 4'hE,
    SSMC_I2C_S_10_INT = 4'hF
  } ssmc_mode_t;

  typedef enum logic [2:0] {
    SSMC_BUS_IDLE = 3'b001,
    SSMC_BUS_ACK  = 3'b010,
    SSMC_BUS_WAIT = 3'b100
  } ssmc_bus_t;
endpackage

// >>> rtl/ssmc_clk_div.sv
`timescale 1ns/1ps
`include "ssmc_consts.svh"
// ---------------------------------------------------------------
// master serial clock tick generator
// ---------------------------------------------------------------
module ssmc_clk_div (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire ssmc_pkg::ssmc_mode_t mode_i,
  input  wire logic [7:0]        baud_i,
  input  wire logic              timer_two_i,
  output logic                   tick_o
);
  import ssmc_pkg::*;

  typedef struct packed {
    logic [9:0] cnt;
    logic       tmr_tgl;
    logic       tick;
  } ssmc_div_t;

  ssmc_div_t s_q, s_d;
  logic [9:0] limit;

  // half-period limit in system clocks, tick toggles the serial clock
  always_comb begin
    limit = 10'h001;
    s_d = s_q;
    s_d.tick = 1'b0;
    case (mode_i)
      SSMC_SPI_M_DIV4:  limit = 10'h001;
      SSMC_SPI_M_DIV16: limit = 10'h007;
      SSMC_SPI_M_DIV64: limit = 10'h01F;
      SSMC_SPI_M_BAUD:  limit = {baud_i, 2'b11} >> 1;
      default:          limit = 10'h001;
    endcase
    if (mode_i == SSMC_SPI_M_TIMER_TWO) begin
      // each timer pulse toggles, giving half the timer rate
      if (timer_two_i) begin
        s_d.tmr_tgl = ~s_q.tmr_tgl;
        s_d.tick = 1'b1;
      end
      s_d.cnt = 10'h000;
    end else if (s_q.cnt >= limit) begin
      s_d.cnt = 10'h000;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 10'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) s_q <= '0;
    else       s_q <= s_d;
  end

  assign tick_o = s_q.tick;
endmodule // ssmc_clk_div

// >>> rtl/ssmc_ctrl.sv
`timescale 1ns/1ps
`include "ssmc_consts.svh"
// Function
// - spi slave: byte arriving while buffer unread sets overflow, byte lost
// - spi master never sets overflow; only spi slave and i2c modes (including firmware i2c master) can
// - i2c: received byte over unread buffer sets overflow; ignored on transmit
// - enable bit hands serial pins to port; clear returns gpio
// - spi polarity bit selects idle clock level
// - i2c slave: polarity bit 1 releases clock, 0 stretches it low
// - modes 0-3: spi master at osc/4, /16, /64, timer/2
// - modes 4,5: spi slave with or without slave select
// - modes 6,7,E,F: i2c slave 7/10 bit, E/F add start/stop interrupts
// - mode A baud-rate spi master, B firmware i2c master, 8/9/C/D reserved
module ssmc_ctrl (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  output logic             irq_o,
  // shift engine side
  input  wire logic        rx_byte_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        i2c_start_i,
  input  wire logic        i2c_stop_i,
  input  wire logic        i2c_tx_i,
  input  wire logic        timer_two_i,
  output logic             tx_load_o,
  output logic [7:0]       tx_data_o,
  output logic             sclk_tick_o,
  output logic             sck_idle_o,
  output logic             clk_hold_o,
  output logic             slave_sel_en_o,
  output logic             addr_10bit_o,
  output logic             i2c_mode_o,
  output logic             spi_slave_o,
  output logic             mode_reserved_o,
  output logic [3:0]       serial_mode_select_o,
  output logic             pin_sel_sck_o,
  output logic             pin_sel_sdo_o,
  output logic             pin_sel_sdi_o,
  output logic             pin_sel_ss_o,
  output logic             pin_sel_scl_o,
  output logic             pin_sel_sda_o
);
  import ssmc_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    ssmc_bus_t   bus;
    logic [31:0] rdata;
    logic        ack;
    logic        ovf;
    logic        en;
    logic        clock_polarity_hold;
    ssmc_mode_t  mode;
    logic [7:0]  baud;
    logic [7:0]  buffer;
    logic        full;
    logic [3:0]  status;
    logic [3:0]  irq_en;
    logic        irq;
    logic        tx_load;
    logic [7:0]  tx_data;
    logic [5:0]  pins;
    logic        idle;
    logic        hold;
    logic        ss_en;
    logic        a10;
    logic        i2c;
    logic        spis;
    logic        rsvd;
  } ssmc_state_t;

  ssmc_state_t s_q, s_d;
  logic        tick;

  function automatic logic is_i2c(input ssmc_mode_t m);
    is_i2c = (m == SSMC_I2C_S_7) || (m == SSMC_I2C_S_10) || (m == SSMC_I2C_M_FW) ||
             (m == SSMC_I2C_S_7_INT) || (m == SSMC_I2C_S_10_INT);
  endfunction

  function automatic logic is_spi_slave(input ssmc_mode_t m);
    is_spi_slave = (m == SSMC_SPI_S_SSEN) || (m == SSMC_SPI_S_NOSS);
  endfunction

  ssmc_clk_div u_div (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .mode_i      (s_q.mode),
    .baud_i      (s_q.baud),
    .timer_two_i (timer_two_i),
    .tick_o      (tick)
  );

  logic wr_hit;
  logic rd_hit;
  logic [3:0] ev;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.tx_load = 1'b0;
    wr_hit = 1'b0;
    rd_hit = 1'b0;
    ev = 4'h0;
    // bus: ack one cycle after strobe, then one idle cycle
    case (s_q.bus)
      SSMC_BUS_IDLE: begin
        if (cyc_i && stb_i) begin
          s_d.bus = SSMC_BUS_ACK;
          s_d.ack = 1'b1;
          wr_hit = we_i;
          rd_hit = ~we_i;
        end
      end
      SSMC_BUS_ACK:  s_d.bus = SSMC_BUS_WAIT;
      SSMC_BUS_WAIT: s_d.bus = SSMC_BUS_IDLE;
      default:       s_d.bus = SSMC_BUS_IDLE;
    endcase

    // read mux; unmapped reads give zero
    if (rd_hit) begin
      case (adr_i)
        `SSMC_OFF_CTRL1:  s_d.rdata = {24'h000000, 1'b0, s_q.ovf, s_q.en, s_q.clock_polarity_hold, s_q.mode};
        `SSMC_OFF_STATUS: s_d.rdata = {28'h0000000, s_q.status};
        `SSMC_OFF_ENABLE: s_d.rdata = {28'h0000000, s_q.irq_en};
        `SSMC_OFF_BAUD:   s_d.rdata = {24'h000000, s_q.baud};
        `SSMC_OFF_DATA:   s_d.rdata = {24'h000000, s_q.buffer};
        default:          s_d.rdata = 32'h00000000;
      endcase
      if (adr_i == `SSMC_OFF_DATA) s_d.full = 1'b0;       // reading frees the buffer
    end

    // register writes on byte lane 0
    if (wr_hit && sel_i[0]) begin
      case (adr_i)
        `SSMC_OFF_CTRL1: begin
          s_d.ovf  = s_q.ovf & dat_i[`SSMC_BIT_OVF];       // software may only clear
          s_d.en   = dat_i[`SSMC_BIT_EN];
          s_d.clock_polarity_hold  = dat_i[`SSMC_BIT_CKP];
          s_d.mode = ssmc_mode_t'(dat_i[`SSMC_MODE_MSB:0]);
        end
        `SSMC_OFF_CLEAR:  s_d.status = s_q.status & ~dat_i[3:0];
        `SSMC_OFF_ENABLE: s_d.irq_en = dat_i[3:0];
        `SSMC_OFF_BAUD:   s_d.baud = dat_i[7:0];
        `SSMC_OFF_DATA: begin
          s_d.tx_data = dat_i[7:0];                        // master transfers start here
          s_d.tx_load = s_q.en;
        end
        default: ;
      endcase
    end

    // receive: byte onto an unread buffer is an overflow in spi slave and i2c receive; spi master overwrites
    if (rx_byte_i && s_q.en) begin
      ev[`SSMC_IRQ_RX] = 1'b1;
      if (s_q.full && (is_spi_slave(s_q.mode) || (is_i2c(s_q.mode) && !i2c_tx_i))) begin
        s_d.ovf = 1'b1;                                    // set wins over clear
        ev[`SSMC_IRQ_OVF] = 1'b1;                          // shift contents dropped
      end else begin
        s_d.buffer = rx_data_i;
        s_d.full = 1'b1;
      end
    end
    // start/stop interrupts only in modes E and F
    if (s_q.en && (s_q.mode == SSMC_I2C_S_7_INT || s_q.mode == SSMC_I2C_S_10_INT)) begin
      ev[`SSMC_IRQ_START] = i2c_start_i;
      ev[`SSMC_IRQ_STOP]  = i2c_stop_i;
    end
    s_d.status = s_d.status | ev;                          // events beat clears
    s_d.irq = |(s_d.status & s_d.irq_en);

    // pin ownership and mode decode
    s_d.pins  = 6'h00;
    if (s_d.en) begin
      if (is_i2c(s_d.mode)) s_d.pins = 6'b110000;          // scl, sda
      else if (s_d.mode == SSMC_SPI_S_SSEN) s_d.pins = 6'b001111;
      else s_d.pins = 6'b000111;                           // ss stays gpio
    end
    s_d.idle  = s_d.clock_polarity_hold & ~is_i2c(s_d.mode);
    s_d.hold  = ~s_d.clock_polarity_hold & is_i2c(s_d.mode) & (s_d.mode != SSMC_I2C_M_FW);
    s_d.ss_en = (s_d.mode == SSMC_SPI_S_SSEN);
    s_d.a10   = (s_d.mode == SSMC_I2C_S_10) || (s_d.mode == SSMC_I2C_S_10_INT);
    s_d.i2c   = is_i2c(s_d.mode);
    s_d.spis  = is_spi_slave(s_d.mode);
    s_d.rsvd  = (s_d.mode == SSMC_RSVD_8) || (s_d.mode == SSMC_RSVD_9) ||
                (s_d.mode == SSMC_RSVD_C) || (s_d.mode == SSMC_RSVD_D);
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q      <= '0;
      s_q.bus  <= SSMC_BUS_IDLE;
      s_q.mode <= ssmc_mode_t'(4'h0);
    end else begin
      s_q <= s_d;
    end
  end

  logic tick_q;
  // master clock tick registered for a flop-driven output; gated by the
  // next mode so that no stale tick leaks out in the cycle a slave mode lands
  always_ff @(posedge clk_i) begin
    if (rst_i) tick_q <= 1'b0;
    else       tick_q <= tick & s_d.en & ~is_i2c(s_d.mode) & ~is_spi_slave(s_d.mode);
  end

  assign dat_o                = s_q.rdata;
  assign ack_o                = s_q.ack;
  assign irq_o                = s_q.irq;
  assign tx_load_o            = s_q.tx_load;
  assign tx_data_o            = s_q.tx_data;
  assign sclk_tick_o          = tick_q;
  assign sck_idle_o           = s_q.idle;
  assign clk_hold_o           = s_q.hold;
  assign slave_sel_en_o       = s_q.ss_en;
  assign addr_10bit_o         = s_q.a10;
  assign i2c_mode_o           = s_q.i2c;
  assign spi_slave_o          = s_q.spis;
  assign mode_reserved_o      = s_q.rsvd;
  assign serial_mode_select_o = s_q.mode;
  assign pin_sel_sck_o        = s_q.pins[0];
  assign pin_sel_sdo_o        = s_q.pins[1];
  assign pin_sel_sdi_o        = s_q.pins[2];
  assign pin_sel_ss_o         = s_q.pins[3];
  assign pin_sel_sda_o        = s_q.pins[4];
  assign pin_sel_scl_o        = s_q.pins[5];
endmodule // ssmc_ctrl

// >>> verification/ssmc_peer.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// shift engine and timer stand-in
// ---------------------------------------------------------------
module ssmc_peer (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       go_i,
  input  wire logic [3:0] gap_i,
  input  wire logic [7:0] byte_i,
  output logic            rx_byte_o,
  output logic [7:0]      rx_data_o,
  output logic            start_o,
  output logic            stop_o,
  output logic            timer_two_o
);
  logic [3:0] cnt_q;
  logic [2:0] tc_q;
  // frame: start beat, byte after gap_i cycles (slow or prompt), stop beat
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 4'h0;
      tc_q <= 3'h0;
      rx_byte_o <= 1'b0;
      rx_data_o <= 8'h00;
      start_o <= 1'b0;
      stop_o <= 1'b0;
      timer_two_o <= 1'b0;
    end else begin
      start_o <= go_i;
      cnt_q <= go_i ? gap_i : (cnt_q != 4'h0 ? cnt_q - 4'h1 : 4'h0);
      rx_byte_o <= (cnt_q == 4'h1);
      rx_data_o <= (cnt_q == 4'h1) ? byte_i : ~rx_data_o; // data only valid with its beat
      stop_o <= rx_byte_o;
      tc_q <= (tc_q == 3'h5) ? 3'h0 : tc_q + 3'h1;
      timer_two_o <= (tc_q == 3'h0); // one match every 6 clocks
    end
  end
endmodule // ssmc_peer

// >>> verification/ssmc_ctrl_asserts.sv
`timescale 1ns/1ps
module ssmc_ctrl_chk (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       ack_o,
  input wire logic       sclk_tick_o,
  input wire logic       sck_idle_o,
  input wire logic       clk_hold_o,
  input wire logic       i2c_mode_o,
  input wire logic       spi_slave_o,
  input wire logic       slave_sel_en_o,
  input wire logic       mode_reserved_o,
  input wire logic [3:0] serial_mode_select_o,
  input wire logic       pin_sel_sck_o,
  input wire logic       pin_sel_scl_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic [3:0] m = serial_mode_select_o;
  ack_once_a: assert property (ack_o |=> !ack_o) else $error("ack wider than one cycle");
  ack_bound_a: assert property (cyc_i && stb_i |-> ##[0:3] ack_o) else $error("no ack");
  pin_split_a: assert property (pin_sel_scl_o |-> i2c_mode_o && !pin_sel_sck_o)
    else $error("pin set wrong");
  idle_spi_a: assert property (sck_idle_o |-> !i2c_mode_o) else $error("idle in i2c");
  hold_i2c_a: assert property (clk_hold_o |-> i2c_mode_o && m != 4'hB) else $error("bad hold");
  slave_dec_a: assert property (spi_slave_o == (m inside {4'h4, 4'h5}) && slave_sel_en_o == (m == 4'h4))
    else $error("slave decode");
  i2c_dec_a: assert property (i2c_mode_o == (m inside {4'h6, 4'h7, 4'hB, 4'hE, 4'hF}))
    else $error("i2c decode");
  rsvd_dec_a: assert property (mode_reserved_o == (m inside {4'h8, 4'h9, 4'hC, 4'hD}))
    else $error("reserved decode");
  tick_master_a: assert property (sclk_tick_o |-> !spi_slave_o && !i2c_mode_o)
    else $error("tick outside master");
  div64_gap_a: assert property (sclk_tick_o && m == 4'h2 |=> (!sclk_tick_o || m != 4'h2) [*8])
    else $error("div64 too fast");
endmodule // ssmc_ctrl_chk
bind ssmc_ctrl ssmc_ctrl_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .sclk_tick_o(sclk_tick_o), .sck_idle_o(sck_idle_o), .clk_hold_o(clk_hold_o),
  .i2c_mode_o(i2c_mode_o), .spi_slave_o(spi_slave_o), .slave_sel_en_o(slave_sel_en_o),
  .mode_reserved_o(mode_reserved_o), .serial_mode_select_o(serial_mode_select_o),
  .pin_sel_sck_o(pin_sel_sck_o), .pin_sel_scl_o(pin_sel_scl_o));

// >>> verification/tb_sync_serial_mode_control.sv
`timescale 1ns/1ps
`include "ssmc_consts.svh"
module tb_sync_serial_mode_control;
  logic        clk, rst, cyc, stb, we, tx, go, irq, ack, rxb, st, sp, tmr, tld, tick, idle, hold;
  logic        ssen, a10, i2c, slv, rsv, psck, psdo, psdi, pss, pscl, psda;
  logic [7:0]  adr, rxd, txd, pb;
  logic [3:0]  mode, gap;
  logic [31:0] wd, rd, r;
  int          bad_count = 0;
  int          cmp_count = 0;
  // per mode: {i2c, spi slave, ss control, 10-bit, reserved, scl pin, ss pin}
  logic [6:0]  dec [16] = '{7'h00, 7'h00, 7'h00, 7'h00, 7'h31, 7'h20, 7'h42, 7'h4A,
                            7'h04, 7'h04, 7'h00, 7'h42, 7'h04, 7'h04, 7'h42, 7'h4A};
  // control byte against {idle level, clock hold, sck pin, ss pin}
  logic [7:0]  pc [6] = '{8'h30, 8'h20, 8'h26, 8'h36, 8'h2B, 8'h04};
  logic [3:0]  pe [6] = '{4'hA, 4'h2, 4'h4, 4'h0, 4'h0, 4'h0};
  ssmc_ctrl u_dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF),
    .dat_i(wd), .dat_o(rd), .ack_o(ack), .irq_o(irq), .rx_byte_i(rxb), .rx_data_i(rxd), .i2c_start_i(st),
    .i2c_stop_i(sp), .i2c_tx_i(tx), .timer_two_i(tmr), .tx_load_o(tld), .tx_data_o(txd), .sclk_tick_o(tick),
    .sck_idle_o(idle), .clk_hold_o(hold), .slave_sel_en_o(ssen), .addr_10bit_o(a10), .i2c_mode_o(i2c),
    .spi_slave_o(slv), .mode_reserved_o(rsv), .serial_mode_select_o(mode), .pin_sel_sck_o(psck),
    .pin_sel_sdo_o(psdo), .pin_sel_sdi_o(psdi), .pin_sel_ss_o(pss), .pin_sel_scl_o(pscl), .pin_sel_sda_o(psda));
  ssmc_peer u_peer (.clk_i(clk), .rst_i(rst), .go_i(go), .gap_i(gap), .byte_i(pb), .rx_byte_o(rxb),
    .rx_data_o(rxd), .start_o(st), .stop_o(sp), .timer_two_o(tmr));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // classic single cycle; read data taken at the ack edge
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = rd;
    if (n >= 20) chk("ack", 1, 0);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task frame(input logic [7:0] b, input logic [3:0] g);
    pb <= b;
    gap <= g;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (int'(g) + 4) @(posedge clk);
  endtask
  // gap between two serial clock ticks
  task per(input logic [7:0] c, input logic [7:0] bd, input int e);
    int n;
    wb(1'b1, `SSMC_OFF_BAUD, {24'h0, bd});
    wb(1'b1, `SSMC_OFF_CTRL1, {24'h0, c});
    n = 0;
    while (tick !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (tick !== 1'b1 && n < 100);
    chk("tick gap", e, n);
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    results;
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; wd = 32'h0; tx = 1'b0; go = 1'b0;
    gap = 4'h1; pb = 8'h00;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, `SSMC_OFF_CTRL1, 0);
    chk("ctrl reset", 0, r);
    chk("pins reset", 0, {psck, psdo, psdi, pss, pscl, psda, irq});
    for (int i = 0; i < 16; i++) begin
      wb(1'b1, `SSMC_OFF_CTRL1, 32'h20 + i);
      wb(1'b0, `SSMC_OFF_CTRL1, 0);
      chk("ctrl", 32'h20 + i, r);
      chk("decode", dec[i], {i2c, slv, ssen, a10, rsv, pscl, pss});
      chk("mode", i, mode);
    end
    for (int k = 0; k < 6; k++) begin
      wb(1'b1, `SSMC_OFF_CTRL1, {24'h0, pc[k]});
      @(posedge clk);
      chk("idle hold pins", pe[k], {idle, hold, psck, pss});
    end
    per(8'h20, 8'h01, 2);
    per(8'h21, 8'h01, 8);
    per(8'h22, 8'h01, 32);
    per(8'h23, 8'h01, 6);
    per(8'h2A, 8'h01, 4);
    per(8'h2A, 8'h03, 8);
    // slave overflow: second byte lands on an unread buffer
    wb(1'b1, `SSMC_OFF_ENABLE, 1);
    wb(1'b1, `SSMC_OFF_CTRL1, 32'h25);
    frame(8'h3C, 4'h1);
    frame(8'hC3, 4'h9);
    chk("irq set", 1, irq);
    wb(1'b0, `SSMC_OFF_CTRL1, 0);
    chk("ovf ctrl", 1, r[6]);
    wb(1'b0, `SSMC_OFF_STATUS, 0);
    chk("ovf status", 1, r[0]);
    wb(1'b0, `SSMC_OFF_DATA, 0);
    chk("kept byte", 8'h3C, r[7:0]);
    wb(1'b1, `SSMC_OFF_ENABLE, 0);
    @(posedge clk);
    chk("irq masked", 0, irq);
    wb(1'b1, `SSMC_OFF_ENABLE, 1);
    wb(1'b1, `SSMC_OFF_CLEAR, 32'hF);
    @(posedge clk);
    chk("irq cleared", 0, irq);
    // spi master never overflows
    wb(1'b1, `SSMC_OFF_CTRL1, 32'h20);
    frame(8'h11, 4'h1);
    frame(8'h22, 4'h1);
    wb(1'b0, `SSMC_OFF_STATUS, 0);
    chk("master ovf", 0, r[0]);
    // i2c: transmit ignores overflow, receive sets it
    wb(1'b0, `SSMC_OFF_DATA, 0);
    wb(1'b1, `SSMC_OFF_CTRL1, 32'h26);
    tx <= 1'b1;
    frame(8'h33, 4'h2);
    frame(8'h44, 4'h2);
    wb(1'b0, `SSMC_OFF_STATUS, 0);
    chk("i2c tx ovf", 0, r[0]);
    tx <= 1'b0;
    wb(1'b0, `SSMC_OFF_DATA, 0);
    frame(8'h55, 4'h2);
    frame(8'h66, 4'h2);
    wb(1'b0, `SSMC_OFF_STATUS, 0);
    chk("i2c rx ovf", 1, r[0]);
    chk("no start stop", 0, r[3:2]);
    // slave read after each byte keeps the flag clear
    wb(1'b1, `SSMC_OFF_CLEAR, 32'hF);
    wb(1'b0, `SSMC_OFF_DATA, 0);
    wb(1'b1, `SSMC_OFF_CTRL1, 32'h2E);
    frame(8'h77, 4'h1);
    wb(1'b0, `SSMC_OFF_DATA, 0);
    frame(8'h88, 4'h1);
    wb(1'b0, `SSMC_OFF_STATUS, 0);
    chk("read each ovf", 0, r[0]);
    chk("start stop", 3, r[3:2]);
    wb(1'b0, 8'h20, 0);
    chk("unmapped", 0, r);
    wb(1'b1, `SSMC_OFF_DATA, 32'h5A);
    @(posedge clk);
    chk("tx data", 8'h5A, txd);
    results;
  end
endmodule // tb_sync_serial_mode_control
